// *** rtl/pqr_params.svh ***
// Offsets, field positions and reset values of the pattern and requantizer register bank
`ifndef PQR_PARAMS_SVH
`define PQR_PARAMS_SVH

// ****************************************
// Register offsets (register index, byte address = 4 * index)
// ****************************************
`define PQR_IDX_PAT_A_HIGH     8'h75
`define PQR_IDX_PAT_B_LOW      8'h76
`define PQR_IDX_PAT_B_HIGH     8'h77
`define PQR_IDX_REQ_FILT       8'h78
`define PQR_IDX_IQ_PP          8'h79
`define PQR_IDX_DECIM_REQ      8'h7A

// ****************************************
// Field positions and reset values
// ****************************************
`define PQR_REQ_RESET_BIT      7
`define PQR_IQ_PP_EN_BIT       7
`define PQR_STAGE1_EN_BIT      6
`define PQR_REQ11_EN_BIT       1
`define PQR_REQ12_EN_BIT       0
`define PQR_REG_RESET          8'h00
`define PQR_NUM_REGS           6
`define PQR_ADDR_W             12

`endif

// *** rtl/pqr_pkg.sv ***
// Types shared by the pattern and requantizer register bank
package pqr_pkg;

    // ****************************************
    // Bus access phase states
    // ****************************************
    typedef enum logic [1:0] {
        PQR_IDLE   = 2'b00,
        PQR_SETUP  = 2'b01,
        PQR_ACCESS = 2'b10
    } pqr_state_t;

    typedef logic [7:0] pqr_byte_t;

endpackage

// *** rtl/pqr_wr_if.sv ***
// Interface carrying decoded register writes from the bus slave to the register store
`timescale 1ns/1ps
interface pqr_wr_if;
    logic                wr_en;
    logic [2:0]          wr_sel;
    pqr_pkg::pqr_byte_t  wr_data;

    modport slave (output wr_en, output wr_sel, output wr_data);
    modport store (input wr_en, input wr_sel, input wr_data);
endinterface

// *** rtl/pqr_reg_store.sv ***
// Storage of the six configuration bytes with toggle detection on the requantizer reset bit
`timescale 1ns/1ps
`include "pqr_params.svh"
module pqr_reg_store
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Write side
    pqr_wr_if.store          wr,
    // Register contents
    output logic [47:0]      regs_flat,
    output logic             req_reset_pulse_d
);

    logic [7:0] regs_q [`PQR_NUM_REGS];

    // ****************************************
    // Register array, one byte per entry
    // ****************************************
    generate
        for (genvar i = 0; i < `PQR_NUM_REGS; i++)
        begin : g_reg
            // Stored value follows the last write; cleared at power-on
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    regs_q[i] <= `PQR_REG_RESET;
                else if (wr.wr_en && wr.wr_sel == 3'(i))
                    regs_q[i] <= wr.wr_data;
            end
            assign regs_flat[i*8 +: 8] = regs_q[i];
        end
    endgenerate

    // New reset bit compared with stored one; equal rewrite does nothing
    always_comb
    begin
        req_reset_pulse_d = wr.wr_en && (wr.wr_sel == 3'd3) &&
            (wr.wr_data[`PQR_REQ_RESET_BIT] != regs_q[3][`PQR_REQ_RESET_BIT]);
    end

endmodule // pqr_reg_store

// *** rtl/pqr_regs.sv ***
// Pattern and requantizer configuration register bank with APB slave
//
// How it works
// - Offset 0x75 holds pattern A bits 11..4 in all eight bits.
// - Offset 0x76 bits 7..4 hold pattern B low nibble.
// - Offset 0x77 holds pattern B upper eight bits.
// - Any change of requantizer reset bit resets the requantizer filter.
// - Offset 0x78 bits 6..0 set the requantizer filter configuration.
// - Offset 0x79 bit 7 enables all I/Q post-processing functions.
// - Offset 0x7A bit 6 enables first 2x decimation stage.
// - Offset 0x7A bit 1 enables the 11-bit requantizer.
// - Offset 0x7A bit 0 enables the 12-bit requantizer.
// - Each enabled stage halves output rate; host updates rate settings.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pqr_params.svh"
module pqr_regs
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pattern outputs
    output logic [11:0]      pattern_a_upper,
    output logic [11:0]      pattern_b,
    output logic [3:0]       pattern_b_unused,
    // Requantizer and decimation controls
    output logic             requantizer_filter_reset,
    output logic [6:0]       requantizer_filter_setting,
    output logic             iq_postproc_enable,
    output logic [6:0]       factory_reserved_iq,
    output logic             first_decimation_stage_enable,
    output logic [4:0]       factory_reserved_decim,
    output logic             requantizer_11bit_enable,
    output logic             requantizer_12bit_enable,
    output logic [1:0]       decimation_rate_log2
);

    // ****************************************
    // Address decode
    // ****************************************

    // Maps a byte address to a register slot, bit 3 flags a hit
    function automatic logic [3:0] pqr_decode(input logic [11:0] addr);
        logic [3:0] r;
        r = 4'h0;
        if (addr[1:0] == 2'b00)
        begin
            case (addr[11:2])
                10'(`PQR_IDX_PAT_A_HIGH): r = 4'h8;
                10'(`PQR_IDX_PAT_B_LOW):  r = 4'h9;
                10'(`PQR_IDX_PAT_B_HIGH): r = 4'hA;
                10'(`PQR_IDX_REQ_FILT):   r = 4'hB;
                10'(`PQR_IDX_IQ_PP):      r = 4'hC;
                10'(`PQR_IDX_DECIM_REQ):  r = 4'hD;
                default:                  r = 4'h0;
            endcase
        end
        return r;
    endfunction

    logic [3:0]  dec;
    logic        access;
    logic [47:0] regs_flat;
    logic        req_reset_pulse_d;
    pqr_pkg::pqr_state_t state_q;

    pqr_wr_if wr ();

    assign dec    = pqr_decode(paddr);
    assign access = psel && penable && (state_q == pqr_pkg::PQR_SETUP);

    // Write strobe: exactly one cycle in the access phase
    always_comb
    begin
        wr.wr_en   = access && pwrite && dec[3];
        wr.wr_sel  = dec[2:0];
        wr.wr_data = pwdata[7:0];
    end

    // ****************************************
    // Register storage
    // ****************************************
    pqr_reg_store u_store
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .wr                (wr.store),
        .regs_flat         (regs_flat),
        .req_reset_pulse_d (req_reset_pulse_d)
    );

    // ****************************************
    // APB phase tracking
    // ****************************************

    // Answer comes one cycle into access so pready is registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= pqr_pkg::PQR_IDLE;
        else
        begin
            case (state_q)
                pqr_pkg::PQR_IDLE:   state_q <= psel ? pqr_pkg::PQR_SETUP : pqr_pkg::PQR_IDLE;
                pqr_pkg::PQR_SETUP:  state_q <= (psel && penable) ? pqr_pkg::PQR_ACCESS : pqr_pkg::PQR_SETUP;
                pqr_pkg::PQR_ACCESS: state_q <= pqr_pkg::PQR_IDLE;
                default:             state_q <= pqr_pkg::PQR_IDLE;
            endcase
        end
    end

    // Ready and error handshake, error for unmapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access;
            pslverr <= access && !dec[3];
        end
    end

    // Read data captured with the answer; upper bits read as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (access && !pwrite && dec[3])
            prdata <= {24'h00_0000, regs_flat[dec[2:0]*8 +: 8]};
        else if (access)
            prdata <= 32'h0000_0000;
    end

    // ****************************************
    // Control outputs, all registered
    // ****************************************

    // Patterns; regs_flat already updated so outputs lag by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pattern_a_upper  <= 12'h000;
            pattern_b        <= 12'h000;
            pattern_b_unused <= 4'h0;
        end
        else
        begin
            pattern_a_upper  <= {regs_flat[7:0], 4'h0};
            pattern_b        <= {regs_flat[23:16], regs_flat[15:12]};
            pattern_b_unused <= regs_flat[11:8];               // Only drives unused test pins
        end
    end

    // Requantizer reset pulse lasts exactly one cycle per toggle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            requantizer_filter_reset <= 1'b0;
        else
            requantizer_filter_reset <= req_reset_pulse_d;
    end

    // Enables and settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            requantizer_filter_setting    <= 7'h00;
            iq_postproc_enable            <= 1'b0;
            factory_reserved_iq           <= 7'h00;
            first_decimation_stage_enable <= 1'b0;
            factory_reserved_decim        <= 5'h00;
            requantizer_11bit_enable      <= 1'b0;
            requantizer_12bit_enable      <= 1'b0;
            decimation_rate_log2          <= 2'h0;
        end
        else
        begin
            requantizer_filter_setting    <= regs_flat[30:24];
            iq_postproc_enable            <= regs_flat[32 + `PQR_IQ_PP_EN_BIT];
            factory_reserved_iq           <= regs_flat[38:32];
            first_decimation_stage_enable <= regs_flat[40 + `PQR_STAGE1_EN_BIT];
            factory_reserved_decim        <= {regs_flat[47], regs_flat[45:42]};
            requantizer_11bit_enable      <= regs_flat[40 + `PQR_REQ11_EN_BIT];
            requantizer_12bit_enable      <= regs_flat[40 + `PQR_REQ12_EN_BIT];
            // Halving factor count seen by this bank: stage one only
            decimation_rate_log2          <= {1'b0, regs_flat[40 + `PQR_STAGE1_EN_BIT]};
        end
    end

endmodule // pqr_regs

// *** verification/pqr_regs_asserts.sv ***
// Port checks for the pattern and requantizer register bank
`timescale 1ns/1ps
module pqr_regs_asserts
(
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Controls
    input wire logic [11:0] pattern_a_upper,
    input wire logic        requantizer_filter_reset,
    input wire logic [6:0]  requantizer_filter_setting,
    input wire logic        iq_postproc_enable,
    input wire logic [6:0]  factory_reserved_iq,
    input wire logic        first_decimation_stage_enable,
    input wire logic        requantizer_11bit_enable,
    input wire logic        requantizer_12bit_enable
);
    // ****************
    // Helper logic
    // ****************
    logic       wr_ok;
    logic       tog;
    logic [7:0] wd_q;
    logic       bit7_q;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign tog = wr_ok && paddr == 12'h1E0 && pwdata[7] != bit7_q;
    // Last written byte; writes are three cycles apart at least
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) wd_q <= 8'h00;
        else if (wr_ok) wd_q <= pwdata[7:0];
    // Shadow of the filter reset bit, to spot toggles
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) bit7_q <= 1'b0;
        else if (wr_ok && paddr == 12'h1E0) bit7_q <= pwdata[7];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not two cycles");
    chk_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr < 12'h1D4 || paddr > 12'h1E8))
        else $error("bad error decode");
    // Pulse is launched by the first access edge, so it stands at the pready edge
    chk_toggle_pulse: assert property (tog |-> requantizer_filter_reset)
        else $error("no filter reset");
    chk_pulse_cause: assert property (requantizer_filter_reset |-> tog)
        else $error("stray filter reset");
    chk_pulse_single: assert property (requantizer_filter_reset |=> !requantizer_filter_reset)
        else $error("filter reset too long");
    chk_filter_set: assert property (wr_ok && paddr == 12'h1E0 |-> ##2 requantizer_filter_setting == wd_q[6:0])
        else $error("filter setting wrong");
    chk_iq_enable: assert property (wr_ok && paddr == 12'h1E4 |-> ##2 {iq_postproc_enable, factory_reserved_iq} == wd_q)
        else $error("iq control wrong");
    chk_decim_sel: assert property (wr_ok && paddr == 12'h1E8 |-> ##2 {first_decimation_stage_enable,
        requantizer_11bit_enable, requantizer_12bit_enable} == {wd_q[6], wd_q[1:0]})
        else $error("decimation select wrong");
    chk_pattern_a: assert property (wr_ok && paddr == 12'h1D4 |-> ##2 pattern_a_upper == {wd_q, 4'h0})
        else $error("pattern a wrong");
    cover property (requantizer_filter_reset);
    cover property (pready && pslverr);
    cover property (pready && !pwrite && !pslverr);
endmodule // pqr_regs_asserts

bind pqr_regs pqr_regs_asserts u_chk
(
    .pclk                          (pclk),
    .presetn                       (presetn),
    .psel                          (psel),
    .penable                       (penable),
    .pwrite                        (pwrite),
    .paddr                         (paddr),
    .pwdata                        (pwdata),
    .prdata                        (prdata),
    .pready                        (pready),
    .pslverr                       (pslverr),
    .pattern_a_upper               (pattern_a_upper),
    .requantizer_filter_reset      (requantizer_filter_reset),
    .requantizer_filter_setting    (requantizer_filter_setting),
    .iq_postproc_enable            (iq_postproc_enable),
    .factory_reserved_iq           (factory_reserved_iq),
    .first_decimation_stage_enable (first_decimation_stage_enable),
    .requantizer_11bit_enable      (requantizer_11bit_enable),
    .requantizer_12bit_enable      (requantizer_12bit_enable)
);

// *** verification/pqr_regs_bench.sv ***
// Self-checking bench for the pattern and requantizer register bank
`timescale 1ns/1ps
`include "pqr_params.svh"
module pqr_regs_bench;
    // ****************
    // Signals
    // ****************
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0, pattern_a_upper, pattern_b;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, requantizer_filter_reset, iq_postproc_enable, er;
    logic        first_decimation_stage_enable, requantizer_11bit_enable, requantizer_12bit_enable;
    logic [3:0]  pattern_b_unused;
    logic [6:0]  requantizer_filter_setting, factory_reserved_iq;
    logic [4:0]  factory_reserved_decim;
    logic [1:0]  decimation_rate_log2;
    int          err_total = 0, check_count = 0, pulses = 0;
    // Factory bits left at zero, unused low nibble of 0x76 kept clear
    logic [7:0]  wv [6] = '{8'hA5, 8'h50, 8'h3C, 8'h2B, 8'h80, 8'h43};

    pqr_regs u_dut
    (
        .pclk                          (pclk),
        .presetn                       (presetn),
        .psel                          (psel),
        .penable                       (penable),
        .pwrite                        (pwrite),
        .paddr                         (paddr),
        .pwdata                        (pwdata),
        .prdata                        (prdata),
        .pready                        (pready),
        .pslverr                       (pslverr),
        .pattern_a_upper               (pattern_a_upper),
        .pattern_b                     (pattern_b),
        .pattern_b_unused              (pattern_b_unused),
        .requantizer_filter_reset      (requantizer_filter_reset),
        .requantizer_filter_setting    (requantizer_filter_setting),
        .iq_postproc_enable            (iq_postproc_enable),
        .factory_reserved_iq           (factory_reserved_iq),
        .first_decimation_stage_enable (first_decimation_stage_enable),
        .factory_reserved_decim        (factory_reserved_decim),
        .requantizer_11bit_enable      (requantizer_11bit_enable),
        .requantizer_12bit_enable      (requantizer_12bit_enable),
        .decimation_rate_log2          (decimation_rate_log2)
    );

    always #12.5 pclk = ~pclk;
    // Count filter reset pulses
    always @(posedge pclk) if (requantizer_filter_reset === 1'b1) pulses++;

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr_settle(input logic [7:0] i, input logic [7:0] d);
        xfer(1, ad(i), d);
        repeat (3) @(posedge pclk);
    endtask

    task automatic read_zero();
        for (int i = 0; i < 6; i++)
        begin
            xfer(0, ad(8'h75 + i), 8'h00);
            cmp("reset_value", 0, rd);
        end
    endtask

    task finish_test;
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge pclk);
        err_total++;
        finish_test;
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        read_zero();
        for (int i = 0; i < 6; i++) xfer(1, ad(8'h75 + i), wv[i]);
        for (int i = 0; i < 6; i++)
        begin
            xfer(0, ad(8'h75 + i), 8'h00);
            cmp("readback", wv[i], rd);
        end
        repeat (3) @(posedge pclk);
        cmp("pattern_a", 12'hA50, pattern_a_upper);
        cmp("pattern_b", 12'h3C5, pattern_b);
        cmp("filter_setting", 7'h2B, requantizer_filter_setting);
        cmp("iq_enable", 1, iq_postproc_enable);
        cmp("factory_bits", 0, {pattern_b_unused, factory_reserved_iq, factory_reserved_decim});
        cmp("stage1_rate", 3'b101, {first_decimation_stage_enable, decimation_rate_log2});
        cmp("req11", 1, requantizer_11bit_enable);
        cmp("req12", 1, requantizer_12bit_enable);
        cmp("no_pulse", 0, pulses);
        wr_settle(`PQR_IDX_REQ_FILT, 8'hAB);
        cmp("pulse_rise", 1, pulses);
        wr_settle(`PQR_IDX_REQ_FILT, 8'hAB);
        cmp("pulse_same", 1, pulses);
        wr_settle(`PQR_IDX_REQ_FILT, 8'h2B);
        cmp("pulse_fall", 2, pulses);
        wr_settle(`PQR_IDX_DECIM_REQ, 8'h00);
        cmp("stage1_off", 0, {first_decimation_stage_enable, decimation_rate_log2});
        xfer(1, ad(8'h7B), 8'hFF);
        cmp("err_write", 1, er);
        xfer(0, ad(8'h7B), 8'h00);
        cmp("err_read", 32'h0000_0001, {rd[30:0], er});
        xfer(0, 12'h1D5, 8'h00);
        cmp("misaligned", 1, er);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        read_zero();
        finish_test;
    end
endmodule // pqr_regs_bench
